// ---- rtl/spi_host_pkg.sv ----
`default_nettype none

package spi_host_pkg;

   // Command port of this controller.
   localparam logic [2:0] REG_CMD = 3'h0;
   localparam logic [2:0] REG_ADDR = 3'h1;
   localparam logic [2:0] REG_COUNT = 3'h2;
   localparam logic [2:0] REG_TX = 3'h3;
   localparam logic [2:0] REG_RX = 3'h4;
   localparam logic [2:0] REG_STATUS = 3'h5;
   localparam logic [2:0] REG_PAGE = 3'h6;
   localparam int CMD_GO_BIT = 0;

   // Link timing: half serial clock period in mclk cycles.
   localparam int SCLK_HALF_DEF = 6;
   localparam int SCLK_HALF_MIN = 3;
   localparam int SCLK_HALF_MAX = 255;

   // Device paging.
   localparam logic [7:0] PAGE_RESET = 8'h00;
   localparam logic [7:0] PAGE_LAST = 8'h04;
   localparam int SOFT_RESET_BIT = 0;

   // Device register map, page 0.
   localparam logic [6:0] PAGE_SELECT = 7'h00;
   localparam logic [6:0] SOFT_RESET_CTRL = 7'h01;
   localparam logic [6:0] SLEEP_CONTROL = 7'h02;
   localparam logic [6:0] SHUTDOWN_CONTROL = 7'h05;
   localparam logic [6:0] AUDIO_PORT_CFG_A = 7'h07;
   localparam logic [6:0] AUDIO_PORT_CFG_B = 7'h08;
   localparam logic [6:0] AUDIO_PORT_CFG_C = 7'h09;
   localparam logic [6:0] SLOT_ASSIGN_CH_ONE = 7'h0b;
   localparam logic [6:0] SLOT_ASSIGN_CH_TWO = 7'h0c;
   localparam logic [6:0] SLOT_ASSIGN_CH_THREE = 7'h0d;
   localparam logic [6:0] SLOT_ASSIGN_CH_FOUR = 7'h0e;
   localparam logic [6:0] SLOT_ASSIGN_CH_FIVE = 7'h0f;
   localparam logic [6:0] SLOT_ASSIGN_CH_SIX = 7'h10;
   localparam logic [6:0] SLOT_ASSIGN_CH_SEVEN = 7'h11;
   localparam logic [6:0] SLOT_ASSIGN_CH_EIGHT = 7'h12;
   localparam logic [6:0] CLOCK_MASTER_CFG_A = 7'h13;
   localparam logic [6:0] CLOCK_MASTER_CFG_B = 7'h14;
   localparam logic [6:0] BUS_CLOCK_MONITOR = 7'h15;
   localparam logic [6:0] CLOCK_SOURCE_CFG = 7'h16;
   localparam logic [6:0] DENSITY_INPUT_EDGE = 7'h20;
   localparam logic [6:0] PIN_IO_CFG_A = 7'h21;
   localparam logic [6:0] PIN_IO_CFG_B = 7'h22;
   localparam logic [6:0] PIN_IO_CFG_C = 7'h23;
   localparam logic [6:0] PIN_INPUT_CFG_A = 7'h24;
   localparam logic [6:0] PIN_INPUT_CFG_B = 7'h25;
   localparam logic [6:0] PIN_OUTPUT_VALUE = 7'h26;
   localparam logic [6:0] PIN_MONITOR_VALUE = 7'h27;
   localparam logic [6:0] IRQ_CONFIG = 7'h28;
   localparam logic [6:0] IRQ_MASK_A = 7'h29;
   localparam logic [6:0] IRQ_MASK_B = 7'h2a;
   localparam logic [6:0] IRQ_MASK_C = 7'h2b;
   localparam logic [6:0] IRQ_LATCHED_A = 7'h2c;
   localparam logic [6:0] DIAG_SUMMARY_LATCHED = 7'h2d;
   localparam logic [6:0] DIAG_LATCHED_CH_ONE = 7'h2e;
   localparam logic [6:0] DIAG_LATCHED_CH_TWO = 7'h2f;
   localparam logic [6:0] DIAG_LATCHED_CH_THREE = 7'h30;
   localparam logic [6:0] DIAG_LATCHED_CH_FOUR = 7'h31;
   localparam logic [6:0] IRQ_MASK_D = 7'h34;
   localparam logic [6:0] IRQ_LATCHED_B = 7'h35;
   localparam logic [6:0] IRQ_LATCHED_C = 7'h36;
   localparam logic [6:0] IRQ_LATCHED_D = 7'h37;
   localparam logic [6:0] MIC_SUPPLY_DIAG_A = 7'h38;

   typedef struct packed {
      logic hold;
      logic rd;
      logic go;
   } cmd_t;

   typedef struct packed {
      logic held;
      logic err;
      logic rx_full;
      logic tx_need;
      logic busy;
   } status_t;

endpackage

`default_nettype wire

// ---- rtl/spi_clock_gen.sv ----
`default_nettype none

module spi_clock_gen
   import spi_host_pkg::*;
#(
   parameter int HALF_CYCLES = SCLK_HALF_DEF
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic run,
   output logic sclk,
   output logic rise,
   output logic fall
);

   logic [7:0] cnt_r;
   logic half_done;

   if (HALF_CYCLES < SCLK_HALF_MIN || HALF_CYCLES > SCLK_HALF_MAX) begin : g_bad_half
      $error("HALF_CYCLES out of range");
   end

   assign half_done = run && cnt_r == 8'(HALF_CYCLES - 1);
   assign rise = half_done && !sclk;
   assign fall = half_done && sclk;

   // Stopping parks the clock low, so the link always idles low between bytes.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 8'h00;
         sclk <= 1'b0;
      end else if (!run) begin
         cnt_r <= 8'h00;
         sclk <= 1'b0;
      end else if (half_done) begin
         cnt_r <= 8'h00;
         sclk <= ~sclk;
      end else begin
         cnt_r <= cnt_r + 8'h01;
      end
   end

   property p_clk_idle;
      @(posedge mclk) disable iff (!rstn)
      !run |=> !sclk;
   endproperty
   a_clk_idle: assert property (p_clk_idle) else $error("sclk not parked low");

endmodule

`default_nettype wire

// ---- rtl/spi_host_ctrl.sv ----
`default_nettype none

module spi_host_ctrl
   import spi_host_pkg::*;
#(
   parameter int HALF_CYCLES = SCLK_HALF_DEF
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [2:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   output logic sclk,
   output logic select_n,
   output logic mosi,
   input wire logic miso
);

   typedef enum logic [2:0] {
      S_IDLE,
      S_SETUP,
      S_SHIFT,
      S_STALL,
      S_END,
      S_GAP
   } state_t;

   state_t state_r;
   cmd_t cmd_r;
   status_t status;
   logic [6:0] reg_addr_r;
   logic [7:0] count_r, tx_r, rx_r, page_r, shift_r, sent_r, wait_r;
   logic [2:0] bit_r;
   logic tx_full_r, rx_full_r, err_r, run_r, is_cmd_r;
   logic miso_m_r, miso_s_r;
   logic rise, fall, go, start, reserved;
   logic wait_done, byte_done, data_done, load_cmd, load_data;
   logic rd_dir, tx_msb;
   logic [7:0] rx_next;

   if (HALF_CYCLES < SCLK_HALF_MIN || HALF_CYCLES > SCLK_HALF_MAX) begin : g_bad_half
      $error("HALF_CYCLES out of range");
   end

   spi_clock_gen #(
      .HALF_CYCLES(HALF_CYCLES)
   ) u_clk (
      .mclk(mclk),
      .rstn(rstn),
      .run(run_r),
      .sclk(sclk),
      .rise(rise),
      .fall(fall)
   );

   assign go = wr_en && addr == REG_CMD && wr_data[CMD_GO_BIT];
   // Only the page-select register stays reachable from a page beyond the last valid one.
   assign reserved = page_r > PAGE_LAST && reg_addr_r != PAGE_SELECT;
   assign start = state_r == S_IDLE && go && !reserved;
   assign wait_done = wait_r == 8'(HALF_CYCLES - 1);
   assign byte_done = fall && bit_r == 3'h7;
   assign data_done = byte_done && !is_cmd_r;
   assign load_cmd = state_r == S_SETUP && wait_done;
   assign load_data = state_r == S_STALL && count_r != 8'h00 && (rd_dir ? !rx_full_r : tx_full_r);
   assign rd_dir = cmd_r.rd;
   assign tx_msb = shift_r[7];
   assign rx_next = {shift_r[6:0], miso_s_r};

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         miso_m_r <= 1'b0;
         miso_s_r <= 1'b0;
      end else begin
         miso_m_r <= miso;
         miso_s_r <= miso_m_r;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_r <= S_IDLE;
      end else begin
         case (state_r)
            S_IDLE: begin
               // A held select skips the command byte and continues the data stream.
               if (start) begin
                  state_r <= select_n ? S_SETUP : S_STALL;
               end
            end
            S_SETUP: begin
               if (wait_done) begin
                  state_r <= S_SHIFT;
               end
            end
            S_SHIFT: begin
               if (byte_done) begin
                  state_r <= S_STALL;
               end
            end
            S_STALL: begin
               if (count_r == 8'h00) begin
                  state_r <= cmd_r.hold ? S_IDLE : S_END;
               end else if (load_data) begin
                  state_r <= S_SHIFT;
               end
            end
            S_END: begin
               if (wait_done) begin
                  state_r <= S_GAP;
               end
            end
            S_GAP: begin
               if (wait_done) begin
                  state_r <= S_IDLE;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wait_r <= 8'h00;
      end else if ((state_r == S_SETUP || state_r == S_END || state_r == S_GAP) && !wait_done) begin
         wait_r <= wait_r + 8'h01;
      end else begin
         wait_r <= 8'h00;
      end
   end

   // A read simply stops being clocked after the counted bytes, and select rises unless the hold bit was set.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         select_n <= 1'b1;
      end else if (start) begin
         select_n <= 1'b0;
      end else if (state_r == S_END && wait_done) begin
         select_n <= 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cmd_r <= '0;
      end else if (start) begin
         cmd_r.hold <= wr_data[2];
         cmd_r.rd <= select_n ? wr_data[1] : cmd_r.rd;
         cmd_r.go <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         run_r <= 1'b0;
      end else if (load_cmd || load_data) begin
         run_r <= 1'b1;
      end else if (byte_done) begin
         run_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         is_cmd_r <= 1'b0;
      end else if (load_cmd) begin
         is_cmd_r <= 1'b1;
      end else if (load_data) begin
         is_cmd_r <= 1'b0;
      end
   end

   // A read loads zeros for MOSI, so all eight MOSI bits of a read byte are zero, while the register byte arrives on MISO.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         shift_r <= 8'h00;
         sent_r <= 8'h00;
         bit_r <= 3'h0;
      end else if (load_cmd) begin
         shift_r <= {reg_addr_r, cmd_r.rd};
         bit_r <= 3'h0;
      end else if (load_data) begin
         shift_r <= rd_dir ? 8'h00 : tx_r;
         sent_r <= tx_r;
         bit_r <= 3'h0;
      end else if (fall) begin
         // MISO settles after the rising edge, so it is taken at the falling edge.
         shift_r <= rx_next;
         bit_r <= bit_r + 3'h1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         mosi <= 1'b0;
      end else if (rise) begin
         mosi <= tx_msb;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         reg_addr_r <= PAGE_SELECT;
      end else if (data_done) begin
         reg_addr_r <= reg_addr_r + 7'h01;
      end else if (state_r == S_IDLE && select_n && wr_en && addr == REG_ADDR) begin
         reg_addr_r <= wr_data[6:0];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         count_r <= 8'h00;
      end else if (data_done) begin
         count_r <= count_r - 8'h01;
      end else if (state_r == S_IDLE && wr_en && addr == REG_COUNT) begin
         count_r <= wr_data;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tx_r <= 8'h00;
         tx_full_r <= 1'b0;
      end else if (wr_en && addr == REG_TX) begin
         tx_r <= wr_data;
         tx_full_r <= 1'b1;
      end else if (load_data && !rd_dir) begin
         tx_full_r <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rx_r <= 8'h00;
         rx_full_r <= 1'b0;
      end else if (data_done && rd_dir) begin
         rx_r <= rx_next;
         rx_full_r <= 1'b1;
      end else if (rd_en && addr == REG_RX) begin
         rx_full_r <= 1'b0;
      end
   end

   // Shadow of the device page, kept so that reserved pages can be refused.
   // TX may be refilled while a byte shifts, so the shadow follows the byte really sent.
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         page_r <= PAGE_RESET;
      end else if (data_done && !rd_dir && reg_addr_r == PAGE_SELECT) begin
         page_r <= sent_r;
      end else if (data_done && !rd_dir && reg_addr_r == SOFT_RESET_CTRL &&
                   page_r == PAGE_RESET && sent_r[SOFT_RESET_BIT]) begin
         page_r <= PAGE_RESET;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         err_r <= 1'b0;
      end else if (state_r == S_IDLE && go && reserved) begin
         err_r <= 1'b1;
      end else if (wr_en && addr == REG_STATUS) begin
         err_r <= 1'b0;
      end
   end

   assign status.held = !select_n && state_r == S_IDLE;
   assign status.err = err_r;
   assign status.rx_full = rx_full_r;
   assign status.tx_need = state_r == S_STALL && !rd_dir && count_r != 8'h00 && !tx_full_r;
   assign status.busy = state_r != S_IDLE;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         case (addr)
            REG_CMD: rd_data <= {5'h00, cmd_r};
            REG_ADDR: rd_data <= {1'b0, reg_addr_r};
            REG_COUNT: rd_data <= count_r;
            REG_RX: rd_data <= rx_r;
            REG_STATUS: rd_data <= {3'h0, status};
            REG_PAGE: rd_data <= page_r;
            default: rd_data <= 8'h00;
         endcase
      end else begin
         rd_data <= 8'h00;
      end
   end

   property p_sel_first;
      @(posedge mclk) disable iff (!rstn)
      $fell(select_n) |-> !sclk [*3];
   endproperty
   a_sel_first: assert property (p_sel_first) else $error("clock moved right after select fell");

   property p_idle_low;
      @(posedge mclk) disable iff (!rstn)
      select_n |-> !sclk && !run_r;
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("clock active while deselected");

   property p_mosi_rise;
      @(posedge mclk) disable iff (!rstn)
      rise |=> mosi == $past(tx_msb) && sclk;
   endproperty
   a_mosi_rise: assert property (p_mosi_rise) else $error("mosi not set at rising edge");

   property p_cmd_load;
      @(posedge mclk) disable iff (!rstn)
      load_cmd |=> shift_r == {$past(reg_addr_r), $past(rd_dir)} && is_cmd_r && run_r;
   endproperty
   a_cmd_load: assert property (p_cmd_load) else $error("bad command byte");

   property p_write_data;
      @(posedge mclk) disable iff (!rstn)
      load_data && !rd_dir |=> shift_r == $past(tx_r) && !is_cmd_r;
   endproperty
   a_write_data: assert property (p_write_data) else $error("bad write byte");

   property p_held_low;
      @(posedge mclk) disable iff (!rstn)
      state_r == S_STALL |-> !select_n;
   endproperty
   a_held_low: assert property (p_held_low) else $error("select rose mid transfer");

   property p_rx_capture;
      @(posedge mclk) disable iff (!rstn)
      data_done && rd_dir |=> rx_full_r && rx_r == $past(rx_next);
   endproperty
   a_rx_capture: assert property (p_rx_capture) else $error("read byte lost");

   property p_step;
      @(posedge mclk) disable iff (!rstn)
      data_done |=> reg_addr_r == $past(reg_addr_r) + 7'h01 && count_r == $past(count_r) - 8'h01;
   endproperty
   a_step: assert property (p_step) else $error("address did not step");

   property p_page;
      @(posedge mclk) disable iff (!rstn)
      data_done && !rd_dir && reg_addr_r == PAGE_SELECT |=> page_r == $past(sent_r);
   endproperty
   a_page: assert property (p_page) else $error("page shadow not updated");

   property p_refuse;
      @(posedge mclk) disable iff (!rstn)
      state_r == S_IDLE && go && reserved |=> err_r && state_r == S_IDLE && !run_r;
   endproperty
   a_refuse: assert property (p_refuse) else $error("reserved page access not refused");

   property p_end_release;
      @(posedge mclk) disable iff (!rstn)
      state_r == S_STALL && count_r == 8'h00 && !cmd_r.hold |-> ##[1:300] select_n;
   endproperty
   a_end_release: assert property (p_end_release) else $error("select never released");

   c_write: cover property (@(posedge mclk) disable iff (!rstn) data_done && !rd_dir);
   c_read: cover property (@(posedge mclk) disable iff (!rstn) data_done && rd_dir);
   c_held: cover property (@(posedge mclk) disable iff (!rstn) status.held);
   c_page: cover property (@(posedge mclk) disable iff (!rstn) $changed(page_r));

endmodule

`default_nettype wire

// ---- tb/codec_reg_model.sv ----
`default_nettype none

module codec_reg_model (
   input wire logic sclk,
   input wire logic select_n,
   input wire logic mosi,
   output logic miso
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:1023];
   logic [7:0] page, sh, cmd;
   logic [7:0] txb = 8'h00;
   logic [6:0] ra;
   int nbits = 0;

   function automatic logic [7:0] dflt(input logic [6:0] a);
      case (a)
         7'h05: return 8'h05;
         7'h07: return 8'h30;
         7'h13: return 8'h02;
         7'h14: return 8'h48;
         7'h15: return 8'hff;
         7'h16: return 8'h10;
         7'h21: return 8'h22;
         7'h29: return 8'hff;
         7'h2a: return 8'h03;
         7'h38: return 8'hba;
         default: return (a >= 7'h0c && a <= 7'h12) ? 8'(a - 7'h0b) : 8'h00;
      endcase
   endfunction

   task automatic reset_map;
      for (int i = 0; i < 1024; i++) mem[i] = (i < 128) ? dflt(7'(i)) : 8'h00;
      page = 8'h00;
   endtask

   // Status registers are read-only on page 0, so writes to them are dropped.
   task automatic put(input logic [6:0] a, input logic [7:0] d);
      if (a == 7'h00) page = d;
      else if (page == 8'h00 && a == 7'h01 && d[0]) reset_map();
      else if (!(page == 8'h00 && (a == 7'h15 || a == 7'h27 || (a >= 7'h2c && a <= 7'h31)
               || (a >= 7'h35 && a <= 7'h37)))) mem[{page[2:0], a}] = d;
   endtask

   initial begin
      miso = 1'b0;
      reset_map();
   end

   always @(negedge select_n) begin
      nbits = 0;
      txb = ~txb;
   end

   always @(negedge sclk) if (!select_n) begin
      sh = {sh[6:0], mosi};
      nbits++;
      if (nbits == 8) begin
         cmd = sh;
         ra = sh[7:1];
      end else if (nbits % 8 == 0) begin
         if (!cmd[0]) put(ra, sh);
         ra = ra + 7'h01;
      end
   end

   always @(posedge sclk) if (!select_n) begin
      if (nbits >= 8 && nbits % 8 == 0 && cmd[0]) txb = (ra == 7'h00) ? page : mem[{page[2:0], ra}];
      miso <= txb[7 - nbits % 8];
   end

   // A released line must not keep the last bit, so it flips instead.
   always @(posedge select_n) miso <= ~miso;
endmodule

`default_nettype wire

// ---- tb/paged_control_port_tb.sv ----
`default_nettype none

module paged_control_port_tb import spi_host_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int H = SCLK_HALF_MIN;
   logic mclk = 1'b0, rstn = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wr_data = 8'h00, rd_data;
   logic sclk, select_n, mosi, miso;
   int bad_count = 0, n_tests = 0, nbits = 0, stray = 0;
   logic [7:0] q [$];
   logic [6:0] da [5] = '{SHUTDOWN_CONTROL, AUDIO_PORT_CFG_A, BUS_CLOCK_MONITOR,
                          SLOT_ASSIGN_CH_EIGHT, MIC_SUPPLY_DIAG_A};
   logic [7:0] dv [5] = '{8'h05, 8'h30, 8'hff, 8'h07, 8'hba};

   initial forever #5 mclk = ~mclk;

   spi_host_ctrl #(.HALF_CYCLES(H)) DUT (.mclk(mclk), .rstn(rstn), .addr(addr),
      .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sclk(sclk),
      .select_n(select_n), .mosi(mosi), .miso(miso));
   codec_reg_model DEV (.sclk(sclk), .select_n(select_n), .mosi(mosi), .miso(miso));

   always @(negedge select_n) nbits = 0;
   always @(posedge sclk) if (select_n) stray++; else nbits++;

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask

   task automatic poll(input int b, input logic want);
      logic [7:0] d;
      int n;
      for (n = 0; n < 3000; n++) begin
         rd(REG_STATUS, d);
         if (d[b] === want) break;
      end
      if (n == 3000) chk("status wait", {7'h00, d[b]}, {7'h00, want});
   endtask

   // Write data come from q; read data are appended to q.
   task automatic xfer(input logic [6:0] ra, input logic rdd, input logic hold, input int cnt);
      logic [7:0] d;
      wr(REG_ADDR, {1'b0, ra});
      wr(REG_COUNT, 8'(cnt));
      if (!rdd && cnt > 0) wr(REG_TX, q.pop_front());
      wr(REG_CMD, {5'h00, hold, rdd, 1'b1});
      for (int i = 0; i < cnt; i++) begin
         if (rdd) begin
            poll(2, 1'b1);
            rd(REG_RX, d);
            q.push_back(d);
         end else if (i + 1 < cnt) begin
            poll(1, 1'b1);
            wr(REG_TX, q.pop_front());
         end
      end
      poll(0, 1'b0);
   endtask

   initial begin
      logic [7:0] d;
      logic [7:0] v [4];
      logic [6:0] a;
      int cnt;
      void'($urandom(32'haab8a750));
      repeat (10) @(posedge mclk);
      rstn <= 1'b1;
      rd(REG_STATUS, d);
      chk("status after reset", d, 8'h00);
      rd(REG_PAGE, d);
      chk("page after reset", d, PAGE_RESET);
      rd(3'h7, d);
      chk("unmapped index", d, 8'h00);
      chk("select idle", {7'h00, select_n}, 8'h01);
      $display("reset test done");
      foreach (da[i]) begin
         xfer(da[i], 1'b1, 1'b0, 1);
         chk("default read", q.pop_front(), dv[i]);
         chk("command byte", DEV.cmd, {da[i], 1'b1});
         chk("read frame bits", 8'(nbits), 8'd16);
      end
      $display("default read test done");
      repeat (3) begin
         a = SLOT_ASSIGN_CH_ONE + 7'($urandom_range(0, 3));
         cnt = $urandom_range(1, 4);
         for (int i = 0; i < cnt; i++) begin
            v[i] = 8'($urandom);
            q.push_back(v[i]);
         end
         xfer(a, 1'b0, 1'b0, cnt);
         chk("command byte", DEV.cmd, {a, 1'b0});
         chk("write frame bits", 8'(nbits), 8'(8 * (cnt + 1)));
         rd(REG_ADDR, d);
         chk("address stepped", d, {1'b0, a + 7'(cnt)});
         xfer(a, 1'b1, 1'b0, cnt);
         for (int i = 0; i < cnt; i++) chk("burst read", q.pop_front(), v[i]);
      end
      $display("burst test done");
      q.push_back(8'h02);
      xfer(PAGE_SELECT, 1'b0, 1'b0, 1);
      rd(REG_PAGE, d);
      chk("page shadow", d, 8'h02);
      v[0] = 8'($urandom);
      q.push_back(v[0]);
      xfer(SHUTDOWN_CONTROL, 1'b0, 1'b0, 1);
      xfer(SHUTDOWN_CONTROL, 1'b1, 1'b0, 1);
      chk("page two data", q.pop_front(), v[0]);
      q.push_back(8'h05);
      xfer(PAGE_SELECT, 1'b0, 1'b0, 1);
      wr(REG_ADDR, 8'h03);
      wr(REG_COUNT, 8'h01);
      wr(REG_CMD, 8'h03);
      rd(REG_STATUS, d);
      chk("reserved page refused", d & 8'h09, 8'h08);
      chk("no frame on refusal", {7'h00, select_n}, 8'h01);
      wr(REG_STATUS, 8'h00);
      rd(REG_STATUS, d);
      chk("error cleared", d & 8'h08, 8'h00);
      q.push_back(8'h00);
      xfer(PAGE_SELECT, 1'b0, 1'b0, 1);
      xfer(SHUTDOWN_CONTROL, 1'b1, 1'b0, 1);
      chk("page zero data", q.pop_front(), 8'h05);
      $display("page test done");
      v[0] = 8'($urandom);
      v[1] = 8'($urandom);
      q.push_back(v[0]);
      xfer(SLOT_ASSIGN_CH_FIVE, 1'b0, 1'b1, 1);
      rd(REG_STATUS, d);
      chk("held flag", d & 8'h10, 8'h10);
      rd(REG_CMD, d);
      chk("command readback", d, 8'h04);
      chk("select kept low", {7'h00, select_n}, 8'h00);
      q.push_back(v[1]);
      xfer(SLOT_ASSIGN_CH_FIVE, 1'b0, 1'b0, 1);
      chk("held frame bits", 8'(nbits), 8'd24);
      xfer(SLOT_ASSIGN_CH_FIVE, 1'b1, 1'b0, 2);
      chk("held first byte", q.pop_front(), v[0]);
      chk("held second byte", q.pop_front(), v[1]);
      $display("held test done");
      q.push_back(8'h01);
      xfer(SOFT_RESET_CTRL, 1'b0, 1'b0, 1);
      rd(REG_PAGE, d);
      chk("page after soft reset", d, PAGE_RESET);
      xfer(SLOT_ASSIGN_CH_FIVE, 1'b1, 1'b0, 1);
      chk("default after soft reset", q.pop_front(), 8'h04);
      chk("clock outside frame", 8'(stray), 8'h00);
      chk("clock idle level", {7'h00, sclk}, 8'h00);
      $display("soft reset test done");
      report_and_stop();
   end

   initial begin
      #400_000;
      bad_count++;
      report_and_stop();
   end
endmodule

`default_nettype wire
